// File: lhsr_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef LHSR_REGS_SVH
`define LHSR_REGS_SVH
`define LHSR_STATUS_OFF 8'h00
`define LHSR_DATA_OFF 8'h04
`define LHSR_CTRL3_OFF 8'h08
`define LHSR_RXDIV_OFF 8'h0C
`define LHSR_TXDIV_OFF 8'h10
`define LHSR_RXEFF_OFF 8'h14
`define LHSR_ST_RX_DATA_FULL_FLAG 0
`define LHSR_ST_FE 1
`define LHSR_ST_PERR 2
`define LHSR_ST_OVR 3
`define LHSR_ST_TDRE 4
`define LHSR_ST_TBUSY 5
`define LHSR_CT_RXEN 0
`define LHSR_CT_TXEN 1
`define LHSR_CT_WORD9 2
`define LHSR_CT_LINEN 3
`define LHSR_CT_SLAVE 4
`define LHSR_CT_HDSEL 5
`define LHSR_CT_RESYNC 6
`define LHSR_CT_PCE 7
`define LHSR_CT_MUTE 8
`define LHSR_CT_HIE 9
`define LHSR_CT_CLKEN 10
`define LHSR_CT_CPOL 11
`define LHSR_CT_CPHA 12
`define LHSR_CT_LBCL 13
`define LHSR_CT_HDF 15
`define LHSR_CTRL_RST 14'h0000
`define LHSR_CLK_HZ 200000000
`define LHSR_MAX_BAUD 500000
`define LHSR_OVERSAMPLE 16
`define LHSR_DIV_RST 16'((`LHSR_CLK_HZ / (`LHSR_OVERSAMPLE * `LHSR_MAX_BAUD)) - 1)
`define LHSR_SAMP_LAST 4'hF
`define LHSR_SAMP_MID_LO 4'h7
`define LHSR_SAMP_MID_HI 4'h9
`define LHSR_HALF_BIT 4'h8
`define LHSR_SYNC_FALLS 3'h4
`define LHSR_SYNC_SHIFT 7
`endif

// File: lhsr_pkg.sv
// types of the serial receiver with header handling
`default_nettype none
package lhsr_pkg;
   typedef enum logic [2:0] {R_IDLE = 3'h0, R_START = 3'h1, R_DATA = 3'h3, R_STOP = 3'h2, R_MEAS = 3'h6} lhsr_rx_t;
   typedef enum logic [1:0] {T_IDLE = 2'h0, T_START = 2'h1, T_DATA = 2'h3, T_STOP = 2'h2} lhsr_tx_t;
   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
      logic wr_pend;
      logic [7:0] waddr;
      logic [13:0] ctrl;
      logic [15:0] rx_div;
      logic [15:0] tx_div;
      logic [15:0] rx_eff;
      logic [15:0] rx_cnt;
      logic [15:0] tx_cnt;
      logic [23:0] meas_cnt;
      logic [2:0] meas_falls;
      lhsr_rx_t rstate;
      logic [3:0] rsc;
      logic [3:0] rbits;
      logic [2:0] samp;
      logic [8:0] rsh;
      logic rx_q;
      logic brk_wait;
      logic [1:0] hdr_cnt;
      logic rx_data_full_flag;
      logic fe;
      logic hdf;
      logic perr;
      logic ovr;
      logic [8:0] rx_data;
      logic irq;
      lhsr_tx_t tstate;
      logic [3:0] tsc;
      logic [3:0] tbits;
      logic [8:0] tsh;
      logic [8:0] tx_buf;
      logic tx_full;
      logic tdo;
      logic tdo_oe;
      logic sclk;
   } lhsr_state_t;
endpackage : lhsr_pkg
`default_nettype wire

// File: lhsr_top.sv
// serial receiver/transmitter with slave header detection, AHB-Lite registers
//
// Function
// - control bit picks break-based (0) or identifier-based (1) header detection.
// - break in break mode outside mute mode sets receive-full flag and loads 0x00 into data.
// - detected header sets the header-detected flag in control register three.
// - header interrupt request raised only with header interrupt enable set.
// - with auto resync on in LIN slave mode, synch field is measured, never loaded, no full flag.
// - with auto resync off, synch field is an ordinary character in break mode, not loaded in identifier mode.
// - in LIN slave mode framing error flags every bad stop except a break.
// - identifier mode sets header and full flags after whole header, id in data.
// - receive state machine halted during synch field measurement.
// - identifier parity checked only in LIN slave mode with parity enable.
// - identifier is third character after break, break counted as first.
// - parity bits are the two top positions, 6/7 or 7/8 by word length.
// - in mute mode only headers are reported, other characters suppressed.
// - transmit line high when enabled and idle, released when disabled.
// - frame is idle, start, 8 or 9 data bits LSB first, one stop.
// - clock output quiet on start/stop, last-bit pulse optional, phase/polarity set.
// - receiver oversamples and takes a three-sample majority per bit.
// - transmit and receive baud divisors programmed independently, both reset to 500K baud.
`timescale 1ns/1ps
`default_nettype none
`include "lhsr_regs.svh"
module lhsr_top (
   input wire logic CLK, // system clock
   input wire logic RSTN, // synchronous reset, low active
   input wire logic HSEL, // slave select
   input wire logic [31:0] HADDR, // byte address
   input wire logic [1:0] HTRANS, // transfer type
   input wire logic HWRITE, // write when high
   input wire logic [2:0] HSIZE, // transfer size, word only
   input wire logic [31:0] HWDATA, // write data
   input wire logic HREADY, // bus ready
   output logic [31:0] HRDATA, // read data
   output logic HREADYOUT, // always ready
   output logic HRESP, // always okay
   input wire logic SERIAL_RX_IN, // serial receive line
   output logic TDO_O, // transmit line level
   output logic TDO_OE, // transmit line driven
   output logic SCLK, // synchronous clock out
   output logic HDR_IRQ // header interrupt request
);
   import lhsr_pkg::*;

   lhsr_state_t st;
   lhsr_state_t nx;
   logic ev_break;
   logic ev_id;
   logic rx_tick;
   logic tx_tick;
   logic stop_bit;
   logic bit_val;
   logic [8:0] word;
   logic [31:0] rd_val;
   logic par_ok;
   logic lin_slave;

   function automatic logic maj3(input logic [2:0] s);
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction : maj3

   always_comb
   begin
      nx = st;
      ev_break = 1'b0;
      ev_id = 1'b0;
      stop_bit = 1'b1;
      word = 9'h000;
      par_ok = 1'b1;
      lin_slave = st.ctrl[`LHSR_CT_LINEN] & st.ctrl[`LHSR_CT_SLAVE];
      bit_val = maj3(st.samp);
      rd_val = 32'h0000_0000;
      unique case (HADDR[7:0])
         `LHSR_STATUS_OFF: rd_val = {26'h0, (st.tstate != T_IDLE), ~st.tx_full, st.ovr, st.perr, st.fe, st.rx_data_full_flag};
         `LHSR_DATA_OFF: rd_val = {23'h0, st.rx_data};
         `LHSR_CTRL3_OFF: rd_val = {16'h0, st.hdf, 1'b0, st.ctrl};
         `LHSR_RXDIV_OFF: rd_val = {16'h0, st.rx_div};
         `LHSR_TXDIV_OFF: rd_val = {16'h0, st.tx_div};
         `LHSR_RXEFF_OFF: rd_val = {16'h0, st.rx_eff};
         default: rd_val = 32'h0000_0000;
      endcase
      // zero wait states; unmapped reads return zero, writes ignored
      nx.hreadyout = 1'b1;
      nx.hresp = 1'b0;
      nx.wr_pend = HSEL & HREADY & HTRANS[1] & HWRITE;
      nx.waddr = HADDR[7:0];
      if (HSEL & HREADY & HTRANS[1] & ~HWRITE)
      begin
         nx.hrdata = rd_val;
      end
      // software writes first so that hardware sets below win over clears
      if (st.wr_pend)
      begin
         unique case (st.waddr)
            `LHSR_STATUS_OFF:
            begin
               nx.rx_data_full_flag = st.rx_data_full_flag & ~HWDATA[`LHSR_ST_RX_DATA_FULL_FLAG];
               nx.fe = st.fe & ~HWDATA[`LHSR_ST_FE];
               nx.perr = st.perr & ~HWDATA[`LHSR_ST_PERR];
               nx.ovr = st.ovr & ~HWDATA[`LHSR_ST_OVR];
            end
            `LHSR_DATA_OFF:
            begin
               if (st.ctrl[`LHSR_CT_TXEN])
               begin
                  nx.tx_buf = HWDATA[8:0];
                  nx.tx_full = 1'b1;
               end
            end
            `LHSR_CTRL3_OFF:
            begin
               nx.ctrl = HWDATA[13:0];
               nx.hdf = st.hdf & ~HWDATA[`LHSR_CT_HDF];
            end
            `LHSR_RXDIV_OFF:
            begin
               nx.rx_div = HWDATA[15:0];
               nx.rx_eff = HWDATA[15:0];
            end
            `LHSR_TXDIV_OFF: nx.tx_div = HWDATA[15:0];
            default: nx.hresp = 1'b0;
         endcase
      end

      // receive oversampling tick, sixteen per bit
      rx_tick = (st.rx_cnt == 16'h0000);
      nx.rx_cnt = rx_tick ? st.rx_eff : st.rx_cnt - 16'h0001;
      nx.rx_q = SERIAL_RX_IN;
      if (!st.ctrl[`LHSR_CT_RXEN])
      begin
         nx.rstate = R_IDLE;
         nx.hdr_cnt = 2'h0;
         nx.brk_wait = 1'b0;
      end
      else
      begin
         unique case (st.rstate)
            R_IDLE:
            begin
               if (st.brk_wait)
               begin
                  nx.brk_wait = ~SERIAL_RX_IN;
               end
               else if (!SERIAL_RX_IN && st.hdr_cnt == 2'h1 && st.ctrl[`LHSR_CT_RESYNC] && lin_slave)
               begin
                  // measure the synch field in clock cycles, character machine off
                  nx.rstate = R_MEAS;
                  nx.meas_cnt = 24'h000000;
                  nx.meas_falls = 3'h0;
               end
               else if (!SERIAL_RX_IN && rx_tick)
               begin
                  nx.rstate = R_START;
                  nx.rsc = 4'h0;
               end
            end
            R_START, R_DATA, R_STOP:
            begin
               if (rx_tick)
               begin
                  nx.rsc = st.rsc + 4'h1;
                  if (st.rsc >= `LHSR_SAMP_MID_LO && st.rsc <= `LHSR_SAMP_MID_HI)
                  begin
                     nx.samp = {st.samp[1:0], SERIAL_RX_IN};
                  end
                  if (st.rsc == `LHSR_SAMP_LAST)
                  begin
                     if (st.rstate == R_START)
                     begin
                        nx.rstate = bit_val ? R_IDLE : R_DATA;
                        nx.rbits = 4'h0;
                     end
                     else if (st.rstate == R_DATA)
                     begin
                        nx.rsh = {bit_val, st.rsh[8:1]};
                        nx.rbits = st.rbits + 4'h1;
                        if (st.rbits == (st.ctrl[`LHSR_CT_WORD9] ? 4'h8 : 4'h7))
                        begin
                           nx.rstate = R_STOP;
                        end
                     end
                     else
                     begin
                        nx.rstate = R_IDLE;
                        stop_bit = bit_val;
                        word = st.ctrl[`LHSR_CT_WORD9] ? st.rsh : {1'b0, st.rsh[8:1]};
                        if (word == 9'h000 && !stop_bit && st.ctrl[`LHSR_CT_LINEN])
                        begin
                           ev_break = 1'b1;
                           nx.brk_wait = 1'b1;
                           nx.hdr_cnt = 2'h1;
                           if (!st.ctrl[`LHSR_CT_HDSEL])
                           begin
                              nx.hdf = 1'b1;
                              if (!st.ctrl[`LHSR_CT_MUTE])
                              begin
                                 nx.rx_data = 9'h000;
                                 nx.rx_data_full_flag = 1'b1;
                                 nx.ovr = nx.ovr | st.rx_data_full_flag;
                              end
                           end
                           if (!st.ctrl[`LHSR_CT_SLAVE])
                           begin
                              nx.fe = 1'b1;
                           end
                        end
                        else
                        begin
                           if (!stop_bit)
                           begin
                              nx.fe = 1'b1;
                           end
                           if (st.hdr_cnt == 2'h2)
                           begin
                              ev_id = 1'b1;
                           end
                           if (st.hdr_cnt != 2'h0 && st.hdr_cnt != 2'h3)
                           begin
                              nx.hdr_cnt = st.hdr_cnt + 2'h1;
                           end
                           if (ev_id && st.ctrl[`LHSR_CT_HDSEL])
                           begin
                              nx.hdf = 1'b1;
                              nx.rx_data_full_flag = 1'b1;
                              nx.rx_data = word;
                              // builds on nx so a same-cycle clear of an old overrun sticks
                              nx.ovr = nx.ovr | st.rx_data_full_flag;
                           end
                           else if (!st.ctrl[`LHSR_CT_MUTE] && !(st.ctrl[`LHSR_CT_HDSEL] && st.hdr_cnt == 2'h1))
                           begin
                              nx.rx_data_full_flag = 1'b1;
                              nx.rx_data = word;
                              nx.ovr = nx.ovr | st.rx_data_full_flag;
                           end
                           if (ev_id && lin_slave && st.ctrl[`LHSR_CT_PCE])
                           begin
                              par_ok = (st.ctrl[`LHSR_CT_WORD9] ? word[7] : word[6]) == ^{word[4], word[2:0]}
                                 && (st.ctrl[`LHSR_CT_WORD9] ? word[8] : word[7]) == ~^{word[5:3], word[1]};
                              nx.perr = nx.perr | ~par_ok;
                           end
                        end
                     end
                  end
               end
            end
            R_MEAS:
            begin
               nx.meas_cnt = st.meas_cnt + 24'h000001;
               if (st.rx_q && !SERIAL_RX_IN)
               begin
                  nx.meas_falls = st.meas_falls + 3'h1;
                  if (st.meas_falls == `LHSR_SYNC_FALLS - 3'h1)
                  begin
                     // eight bit times span 128 ticks
                     nx.rx_eff = (st.meas_cnt[23:`LHSR_SYNC_SHIFT] > 17'h00001)
                        ? 16'(st.meas_cnt[23:`LHSR_SYNC_SHIFT] - 17'h00001) : st.rx_eff;
                     nx.hdr_cnt = 2'h2;
                     nx.brk_wait = 1'b1;
                     nx.rstate = R_IDLE;
                  end
               end
            end
            default: nx.rstate = R_IDLE;
         endcase
      end
      nx.irq = nx.hdf & nx.ctrl[`LHSR_CT_HIE];

      // transmitter, own divisor, sixteen ticks per bit
      tx_tick = (st.tx_cnt == 16'h0000);
      nx.tx_cnt = tx_tick ? st.tx_div : st.tx_cnt - 16'h0001;
      if (!st.ctrl[`LHSR_CT_TXEN])
      begin
         nx.tstate = T_IDLE;
         nx.tx_full = 1'b0;
      end
      else if (tx_tick)
      begin
         nx.tsc = st.tsc + 4'h1;
         unique case (st.tstate)
            T_IDLE:
            begin
               if (st.tx_full)
               begin
                  nx.tsh = st.tx_buf;
                  nx.tx_full = 1'b0;
                  nx.tstate = T_START;
                  nx.tsc = 4'h0;
               end
            end
            T_START:
            begin
               if (st.tsc == `LHSR_SAMP_LAST)
               begin
                  nx.tstate = T_DATA;
                  nx.tbits = 4'h0;
               end
            end
            T_DATA:
            begin
               if (st.tsc == `LHSR_SAMP_LAST)
               begin
                  nx.tsh = {1'b0, st.tsh[8:1]};
                  nx.tbits = st.tbits + 4'h1;
                  if (st.tbits == (st.ctrl[`LHSR_CT_WORD9] ? 4'h8 : 4'h7))
                  begin
                     nx.tstate = T_STOP;
                  end
               end
            end
            T_STOP:
            begin
               if (st.tsc == `LHSR_SAMP_LAST)
               begin
                  nx.tstate = T_IDLE;
               end
            end
         endcase
      end
      nx.tdo_oe = nx.ctrl[`LHSR_CT_TXEN];
      nx.tdo = (nx.tstate == T_START) ? 1'b0 : (nx.tstate == T_DATA) ? nx.tsh[0] : 1'b1;
      nx.sclk = nx.ctrl[`LHSR_CT_CPOL]
         ^ (nx.ctrl[`LHSR_CT_CLKEN] && nx.tstate == T_DATA
            && (nx.ctrl[`LHSR_CT_LBCL] || nx.tbits != (nx.ctrl[`LHSR_CT_WORD9] ? 4'h8 : 4'h7))
            && (nx.ctrl[`LHSR_CT_CPHA] ? (nx.tsc < `LHSR_HALF_BIT) : (nx.tsc >= `LHSR_HALF_BIT)));
   end

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         st <= '0;
         st.hreadyout <= 1'b1;
         st.ctrl <= `LHSR_CTRL_RST;
         st.rx_div <= `LHSR_DIV_RST;
         st.tx_div <= `LHSR_DIV_RST;
         st.rx_eff <= `LHSR_DIV_RST;
         st.rx_q <= 1'b1;
         st.tdo <= 1'b1;
         st.sclk <= 1'b0;
      end
      else
      begin
         st <= nx;
      end
   end

   assign HRDATA = st.hrdata;
   assign HREADYOUT = st.hreadyout;
   assign HRESP = st.hresp;
   assign TDO_O = st.tdo;
   assign TDO_OE = st.tdo_oe;
   assign SCLK = st.sclk;
   assign HDR_IRQ = st.irq;

   sequence s_break_mode0;
      ev_break && !st.ctrl[`LHSR_CT_HDSEL];
   endsequence

   sequence s_header_seen;
      ##1 st.hdf;
   endsequence

   chk_hdr_irq_gate: assert property (@(posedge CLK) disable iff (!RSTN)
      HDR_IRQ |-> st.hdf && st.ctrl[`LHSR_CT_HIE]) else $error("header irq without enable");
   chk_break_hdf_set: assert property (@(posedge CLK) disable iff (!RSTN)
      s_break_mode0 |-> s_header_seen) else $error("break did not set header flag");
   chk_break_data_zero: assert property (@(posedge CLK) disable iff (!RSTN)
      s_break_mode0 and !st.ctrl[`LHSR_CT_MUTE] |=> st.rx_data_full_flag && st.rx_data == 9'h000)
      else $error("break did not load zero data");
   chk_meas_no_rx_data_full_flag: assert property (@(posedge CLK) disable iff (!RSTN)
      st.rstate == R_MEAS && !st.rx_data_full_flag |=> !st.rx_data_full_flag) else $error("data loaded during synch measurement");
   chk_slave_break_fe: assert property (@(posedge CLK) disable iff (!RSTN)
      ev_break && st.ctrl[`LHSR_CT_SLAVE] && !st.fe |=> !st.fe) else $error("framing error on break");
   chk_id_header: assert property (@(posedge CLK) disable iff (!RSTN)
      ev_id && st.ctrl[`LHSR_CT_HDSEL] |=> st.hdf && st.rx_data_full_flag) else $error("identifier did not flag header");
   chk_parity_off: assert property (@(posedge CLK) disable iff (!RSTN)
      ev_id && !(lin_slave && st.ctrl[`LHSR_CT_PCE]) && !st.perr |=> !st.perr) else $error("parity checked while off");
   chk_tdo_idle_high: assert property (@(posedge CLK) disable iff (!RSTN)
      st.ctrl[`LHSR_CT_TXEN] && st.tstate == T_IDLE ##1 st.ctrl[`LHSR_CT_TXEN] && st.tstate == T_IDLE
      |-> TDO_O && TDO_OE) else $error("transmit line not high when idle");
   chk_sclk_quiet: assert property (@(posedge CLK) disable iff (!RSTN)
      (st.tstate == T_START || st.tstate == T_STOP) |-> SCLK == st.ctrl[`LHSR_CT_CPOL])
      else $error("clock pulse on start or stop bit");
   chk_mute_quiet: assert property (@(posedge CLK) disable iff (!RSTN)
      st.ctrl[`LHSR_CT_MUTE] && !ev_id && !st.rx_data_full_flag |=> !st.rx_data_full_flag) else $error("character reported in mute");
endmodule : lhsr_top
`default_nettype wire

// File: lhsr_lin_peer.sv
// bus master model: drives the receive line, samples the transmit line
`timescale 1ns/1ps
`default_nettype none
module lhsr_lin_peer #(
   parameter int BIT = 66
)(
   input wire logic clk, // system clock
   input wire logic tdo_i, // device transmit line
   output logic line_o // device receive line
);
   // bus has a pull-up, so idle reads high
   initial line_o = 1'b1;

   // start, data lsb first, stop; a low stop with zero data is a break
   task automatic send(input logic [8:0] d, input int nb, input logic stp);
      line_o <= 1'b0;
      repeat (BIT) @(posedge clk);
      for (int i = 0; i < nb; i++)
      begin
         line_o <= d[i];
         repeat (BIT) @(posedge clk);
      end
      line_o <= stp;
      repeat (BIT) @(posedge clk);
      line_o <= 1'b1;
      repeat (3 * BIT) @(posedge clk);
   endtask : send

   // samples mid bit; waits for the start bit without any time limit
   task automatic recv(input int per, output logic [7:0] d);
      while (tdo_i !== 1'b0)
         @(posedge clk);
      repeat (per + per / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         d[i] = tdo_i;
         repeat (per) @(posedge clk);
      end
   endtask : recv
endmodule : lhsr_lin_peer
`default_nettype wire

// File: lhsr_top_tb.sv
// self-checking bench of the serial receiver with header detection
`timescale 1ns/1ps
`default_nettype none
`include "lhsr_regs.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module lhsr_top_tb;
   localparam int BIT = 66;
   localparam logic [31:0] LIN = (32'h1 << `LHSR_CT_RXEN) | (32'h1 << `LHSR_CT_LINEN) | (32'h1 << `LHSR_CT_SLAVE);
   localparam logic [31:0] RXEN = 32'h1 << `LHSR_CT_RXEN;
   localparam logic [31:0] W9 = 32'h1 << `LHSR_CT_WORD9;
   localparam logic [31:0] HDS = 32'h1 << `LHSR_CT_HDSEL;
   localparam logic [31:0] RS = 32'h1 << `LHSR_CT_RESYNC;
   localparam logic [31:0] PARITY_CHECK_ENABLE = 32'h1 << `LHSR_CT_PCE;
   localparam logic [31:0] MUTE = 32'h1 << `LHSR_CT_MUTE;
   localparam logic [31:0] HIE = 32'h1 << `LHSR_CT_HIE;
   localparam logic [31:0] TXC = (32'h1 << `LHSR_CT_TXEN) | (32'h1 << `LHSR_CT_CLKEN) | (32'h1 << `LHSR_CT_CPOL);
   localparam logic [31:0] LBCP = (32'h1 << `LHSR_CT_LBCL) | (32'h1 << `LHSR_CT_CPHA);
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hrdata;
   logic hreadyout, hresp, tdo, tdo_oe, sclk, irq, line;
   logic [31:0] seed = 32'h3068EE1D;
   logic [31:0] rd;
   logic [31:0] ctrl = 32'h0;
   int num_errors = 0;
   int n_tests = 0;
   int n_sclk = 0;
   logic sclk_q = 1'b0;

   always #2.5 clk = ~clk;

   // falling edges of the clock output, counted for the pulse check
   always @(posedge clk)
   begin
      sclk_q <= sclk;
      if (sclk_q && !sclk)
         n_sclk++;
   end

   lhsr_top u_dut (.CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
      .HRESP(hresp), .SERIAL_RX_IN(line), .TDO_O(tdo), .TDO_OE(tdo_oe), .SCLK(sclk), .HDR_IRQ(irq));
   // a released transmit pin reads the bus pull-up
   lhsr_lin_peer #(.BIT(BIT)) u_peer (.clk(clk), .tdo_i(tdo_oe ? tdo : 1'b1), .line_o(line));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // identifier with its two parity bits in the top positions
   function automatic logic [8:0] lin_id(input logic [5:0] id, input logic w9, input logic bad);
      logic p0, p1;
      p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
      p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]) ^ bad;
      return w9 ? {p1, p0, 1'b0, id} : {1'b0, p1, p0, id};
   endfunction : lin_id

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb

   task automatic setc(input logic [31:0] c);
      ctrl = c;
      ahb(1'b1, `LHSR_CTRL3_OFF, c);
   endtask : setc

   // checks flags and data, then clears the sticky flags
   task automatic chk_rx(input logic [3:0] st, input logic hd, input logic [8:0] d, input logic dchk);
      ahb(1'b0, `LHSR_STATUS_OFF, 32'h0);
      `CHK(rd[3:0], st)
      `CHK(irq, hd & ctrl[`LHSR_CT_HIE])
      ahb(1'b0, `LHSR_CTRL3_OFF, 32'h0);
      `CHK(rd[`LHSR_CT_HDF], hd)
      if (dchk)
      begin
         ahb(1'b0, `LHSR_DATA_OFF, 32'h0);
         `CHK(rd[8:0], d)
      end
      ahb(1'b1, `LHSR_STATUS_OFF, 32'hF);
      ahb(1'b1, `LHSR_CTRL3_OFF, ctrl | 32'h8000);
   endtask : chk_rx

   task automatic report_and_stop();
      $display("counts: tests=%0d errors=%0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop

   // whole run needs about 24k cycles
   initial
   begin
      repeat (80000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end

   initial
   begin
      logic [8:0] d;
      logic [7:0] t;
      logic bad, parity_check_enable, w9;
      int n;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      `CHK({tdo, tdo_oe, sclk, irq, hresp, hreadyout}, 6'h21)
      ahb(1'b0, `LHSR_CTRL3_OFF, 32'h0);
      `CHK(rd, 32'h0)
      ahb(1'b0, `LHSR_RXDIV_OFF, 32'h0);
      `CHK(rd, 32'(`LHSR_DIV_RST))
      ahb(1'b0, 8'h40, 32'h0);
      `CHK(rd, 32'h0)
      ahb(1'b1, `LHSR_RXDIV_OFF, 32'h3);
      ahb(1'b1, `LHSR_TXDIV_OFF, 32'h5);
      $display("test registers done");
      for (int i = 0; i < 4; i++)
      begin
         w9 = (i == 3);
         setc(RXEN | (w9 ? W9 : 32'h0));
         d = 9'(rnd()) & (w9 ? 9'h1FF : 9'h0FF);
         u_peer.send(d, w9 ? 9 : 8, 1'b1);
         chk_rx(4'h1, 1'b0, d, 1'b1);
      end
      setc(LIN);
      u_peer.send(9'h07E, 8, 1'b0);
      chk_rx(4'h3, 1'b0, 9'h07E, 1'b1);
      $display("test characters done");
      for (int r = 0; r < 2; r++)
      begin
         setc(LIN | PARITY_CHECK_ENABLE | (r ? RS | HIE : 32'h0));
         u_peer.send(9'h0, 8, 1'b0);
         chk_rx(4'h1, 1'b1, 9'h0, 1'b1);
         u_peer.send(9'h055, 8, 1'b1);
         chk_rx(r ? 4'h0 : 4'h1, 1'b0, 9'h055, r == 0);
         ahb(1'b0, `LHSR_RXEFF_OFF, 32'h0);
         if (r)
            `CHK(rd[15:0], 16'((8 * BIT) / 128 - 1))
         bad = rnd() & 32'h1;
         d = lin_id(6'(rnd()), 1'b0, bad);
         u_peer.send(d, 8, 1'b1);
         chk_rx({1'b0, bad, 2'h1}, 1'b0, d, 1'b1);
      end
      $display("test break mode done");
      for (int k = 0; k < 4; k++)
      begin
         w9 = k & 1;
         n = w9 ? 9 : 8;
         // parity off at least once, a bad checked identifier at least once
         parity_check_enable = (k == 3) | ((k != 0) & rnd() & 32'h1);
         bad = (k == 3) | (rnd() & 32'h1);
         setc(LIN | HDS | HIE | (w9 ? W9 : 32'h0) | (k > 1 ? RS : 32'h0) | (parity_check_enable ? PARITY_CHECK_ENABLE : 32'h0));
         u_peer.send(9'h0, n, 1'b0);
         chk_rx(4'h0, 1'b0, 9'h0, 1'b0);
         u_peer.send(9'h055, n, 1'b1);
         chk_rx(4'h0, 1'b0, 9'h0, 1'b0);
         d = lin_id(6'(rnd()), w9, bad);
         u_peer.send(d, n, 1'b1);
         chk_rx({1'b0, bad & parity_check_enable, 2'h1}, 1'b1, d, 1'b1);
      end
      $display("test identifier mode done");
      setc(LIN | MUTE | HIE);
      u_peer.send(9'(rnd()) & 9'h0FF, 8, 1'b1);
      chk_rx(4'h0, 1'b0, 9'h0, 1'b0);
      u_peer.send(9'h0, 8, 1'b0);
      chk_rx(4'h0, 1'b1, 9'h0, 1'b0);
      $display("test mute done");
      setc(TXC);
      repeat (4) @(posedge clk);
      `CHK({tdo, tdo_oe, sclk}, 3'h7)
      for (int i = 0; i < 2; i++)
      begin
         setc(TXC | (i ? LBCP : 32'h0));
         d = 9'(rnd()) & 9'h0FF;
         ahb(1'b1, `LHSR_DATA_OFF, {23'h0, d});
         u_peer.recv(96, t);
         `CHK(t, d[7:0])
      end
      repeat (200) @(posedge clk);
      // seven pulses without the last bit, eight with it
      `CHK(n_sclk, 15)
      setc(32'h0);
      repeat (4) @(posedge clk);
      `CHK(tdo_oe, 1'b0)
      $display("test transmit done");
      report_and_stop();
   end
endmodule : lhsr_top_tb
`default_nettype wire
